//--- shared/cordic_pkg.sv
// Shared constants and types for the CORDIC math solver
package cordic_pkg;
    localparam int WORD_W = 32;
    localparam int DWORD_W = 64;
    localparam int CORE_COUNT = 8;
    localparam int CORE_W = 3;
    localparam int SLOT_PERIOD = 8;
    localparam int PIPE_STAGES = 54;
    localparam int WORK_STAGES = 32;
    localparam int RESULT_LATENCY = 55;
    localparam int LOG_EXP_W = 5;
    localparam int LOG_MANT_W = 27;
    localparam int GAIN_PROD_W = DWORD_W + WORD_W + 1;
    // Inverse of the CORDIC gain in 0.32 fixed point
    localparam logic [WORD_W-1:0] GAIN_INV = 32'h9B74EDA8;
    localparam logic [WORD_W-1:0] HALF_TURN = 32'h80000000;
    localparam real TWO_PI = 6.283185307179586;
    localparam real TURN_SCALE = 4294967296.0;

    typedef enum logic [3:0] {
        OP_MUL = 4'h0,
        OP_INT_DIV = 4'h1,
        OP_FRAC_DIV = 4'h2,
        OP_SQRT = 4'h3,
        OP_ROTATE = 4'h4,
        OP_VECTOR = 4'h5,
        OP_LOG = 4'h6,
        OP_EXP = 4'h7,
        OP_EXTEND = 4'h8,
        OP_READ_X = 4'h9,
        OP_READ_Y = 4'hA
    } op_t;
endpackage

//--- rtl/log_exp_unit.sv
// Integer to 5:27 logarithm and back, combinational
`timescale 1ns/1ps
module log_exp_unit (
    input wire logic toInteger,
    input wire logic [cordic_pkg::WORD_W-1:0] value,
    output logic [cordic_pkg::WORD_W-1:0] result
);
    import cordic_pkg::*;

    localparam logic [LOG_EXP_W-1:0] TOP_BIT = LOG_EXP_W'(WORD_W - 1);

    function automatic logic [LOG_EXP_W-1:0] leadingOne(input logic [WORD_W-1:0] v);
        leadingOne = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (v[i]) begin
                leadingOne = LOG_EXP_W'(i);
            end
        end
    endfunction

    wire logic [LOG_EXP_W-1:0] msb = leadingOne(value);
    wire logic [WORD_W-1:0] normal = value << (TOP_BIT - msb);
    // Mantissa is the linear fraction below the leading one
    wire logic [LOG_MANT_W-1:0] logMant = normal[WORD_W-2 -: LOG_MANT_W];
    wire logic [LOG_EXP_W-1:0] expPart = value[WORD_W-1 -: LOG_EXP_W];
    wire logic [DWORD_W-1:0] mantOne = DWORD_W'({1'b1, value[LOG_MANT_W-1:0]}) << expPart;
    wire logic [WORD_W-1:0] intVal = mantOne[LOG_MANT_W +: WORD_W];

    assign result = toInteger ? intVal : {msb, logMant};
endmodule // log_exp_unit

//--- rtl/cordic_stage.sv
// One registered stage of the solver pipeline
`timescale 1ns/1ps
module cordic_stage #(
    parameter int IDX = 0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [cordic_pkg::CORE_W-1:0] inCore,
    input wire cordic_pkg::op_t inOp,
    input wire logic [cordic_pkg::DWORD_W-1:0] inP0,
    input wire logic [cordic_pkg::DWORD_W-1:0] inP1,
    input wire logic [cordic_pkg::WORD_W-1:0] inP2,
    output logic outValid,
    output logic [cordic_pkg::CORE_W-1:0] outCore,
    output cordic_pkg::op_t outOp,
    output logic [cordic_pkg::DWORD_W-1:0] outP0,
    output logic [cordic_pkg::DWORD_W-1:0] outP1,
    output logic [cordic_pkg::WORD_W-1:0] outP2
);
    import cordic_pkg::*;

    logic [DWORD_W-1:0] next_p0;
    logic [DWORD_W-1:0] next_p1;
    logic [WORD_W-1:0] next_p2;

    generate
        if (IDX < WORK_STAGES) begin : g_work
            localparam int BITPOS = WORK_STAGES - 1 - IDX;
            localparam real ANGLE_TURNS = $atan(2.0 ** (-IDX)) / TWO_PI * TURN_SCALE;
            localparam logic [WORD_W-1:0] STEP_ANGLE = WORD_W'(longint'(ANGLE_TURNS));
            wire logic [DWORD_W-1:0] addend = inP0 << IDX;
            wire logic [DWORD_W-1:0] divTrial = inP0 << BITPOS;
            wire logic [DWORD_W-1:0] rootTrial =
                (DWORD_W'(inP2) << (BITPOS + 1)) + (DWORD_W'(1) << (2 * BITPOS));
            wire logic signed [DWORD_W-1:0] xs = $signed(inP0) >>> IDX;
            wire logic signed [DWORD_W-1:0] ys = $signed(inP1) >>> IDX;
            // Rotation steers by angle sign, vectoring by Y sign
            wire logic turnPos = (inOp == OP_ROTATE) ? ~inP2[WORD_W-1] : inP1[DWORD_W-1];
            always_comb begin
                next_p0 = inP0;
                next_p1 = inP1;
                next_p2 = inP2;
                case (inOp)
                    OP_MUL: begin
                        if (inP2[IDX]) begin
                            next_p1 = inP1 + addend;
                        end
                    end
                    OP_INT_DIV, OP_FRAC_DIV: begin
                        if (inP1 >= divTrial) begin
                            next_p1 = inP1 - divTrial;
                            next_p2[BITPOS] = 1'b1;
                        end
                    end
                    OP_SQRT: begin
                        if (inP1 >= rootTrial) begin
                            next_p1 = inP1 - rootTrial;
                            next_p2[BITPOS] = 1'b1;
                        end
                    end
                    OP_ROTATE, OP_VECTOR: begin
                        next_p0 = turnPos ? inP0 - ys : inP0 + ys;
                        next_p1 = turnPos ? inP1 + xs : inP1 - xs;
                        next_p2 = turnPos ? inP2 - STEP_ANGLE : inP2 + STEP_ANGLE;
                    end
                    default: begin
                        next_p2 = inP2;
                    end
                endcase
            end
        end else begin : g_pass
            assign next_p0 = inP0;
            assign next_p1 = inP1;
            assign next_p2 = inP2;
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            outValid <= 1'b0;
        end else begin
            outValid <= inValid;
        end
    end

    always_ff @(posedge clk_sys) begin
        outCore <= inCore;
        outOp <= inOp;
        outP0 <= next_p0;
        outP1 <= next_p1;
        outP2 <= next_p2;
    end
endmodule // cordic_stage

//--- rtl/cordic_solver.sv
// Shared pipelined CORDIC math solver, top level
// Overview of operation
// - One shared 54-stage pipeline serves every core
// - Multiply: unsigned 32x32, X low, Y high
// - Divide 64 by 32: X quotient, Y remainder
// - Integer and fractional divide, optional extension first
// - Square root of 64 bits into X
// - Rotate signed point by unsigned angle
// - Vector: cartesian to length X, angle Y
// - Rotate of length and angle gives cartesian
// - Log: integer to 5:27 exponent and mantissa
// - Exp: 5:27 logarithm back to integer
// - One command per core slot, every eight clocks
// - Results ready 55 clocks after issue
// - Back-to-back slots give one result per eight clocks
// - Results kept apart per core, one X and Y pair each
// - Uncollected result overwritten by the next
// - X and Y read by separate commands
`timescale 1ns/1ps
module cordic_solver (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [cordic_pkg::CORE_W-1:0] cmdCore,
    input wire cordic_pkg::op_t cmdOp,
    input wire logic [cordic_pkg::WORD_W-1:0] cmdA,
    input wire logic [cordic_pkg::WORD_W-1:0] cmdB,
    output logic [cordic_pkg::CORE_W-1:0] slotCore,
    output logic cmdRefused,
    output logic rdDataValid,
    output logic rdFresh,
    output logic [cordic_pkg::WORD_W-1:0] rdData,
    output logic resultLost
);
    import cordic_pkg::*;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [DWORD_W-1:0] dword_t;

    // Fraction bits carried through the rotate and vector modes
    localparam int GUARD_W = 24;

    logic [CORE_W-1:0] next_slotCore;
    word_t extendWord [CORE_COUNT];
    word_t resultX [CORE_COUNT];
    word_t resultY [CORE_COUNT];
    logic [CORE_COUNT-1:0] freshX;
    logic [CORE_COUNT-1:0] freshY;
    logic [CORE_COUNT-1:0] next_freshX;
    logic [CORE_COUNT-1:0] next_freshY;

    // Pipeline links, index 0 is the issue point
    logic stValid [PIPE_STAGES+1];
    logic [CORE_W-1:0] stCore [PIPE_STAGES+1];
    op_t stOp [PIPE_STAGES+1];
    dword_t stP0 [PIPE_STAGES+1];
    dword_t stP1 [PIPE_STAGES+1];
    word_t stP2 [PIPE_STAGES+1];

    dword_t issueP0;
    dword_t issueP1;
    word_t issueP2;
    word_t logExpOut;
    word_t finX;
    word_t finY;

    // Command decode
    wire logic isSolverOp = cmdValid && (cmdOp < OP_EXTEND);
    wire logic inSlot = (cmdCore == slotCore);
    wire logic issue = isSolverOp && inSlot;
    wire logic refuse = isSolverOp && !inSlot;
    wire logic isExtend = cmdValid && (cmdOp == OP_EXTEND);
    wire logic readX = cmdValid && (cmdOp == OP_READ_X);
    wire logic readY = cmdValid && (cmdOp == OP_READ_Y);
    wire word_t extWord = extendWord[cmdCore];

    // Operand shaping for the CORDIC modes
    wire logic flipRot = cmdB[WORD_W-1] ^ cmdB[WORD_W-2];
    wire logic flipVec = cmdA[WORD_W-1];
    wire word_t ySource = (cmdOp == OP_ROTATE) ? extWord : cmdB;
    // Guard bits keep shift truncation far below one result LSB
    // Costs only adder width, the 64-bit links have the headroom
    wire dword_t xWide = {{WORD_W{cmdA[WORD_W-1]}}, cmdA} << GUARD_W;
    wire dword_t yWide = {{WORD_W{ySource[WORD_W-1]}}, ySource} << GUARD_W;

    // End of pipeline
    wire logic endValid = stValid[PIPE_STAGES];
    wire logic [CORE_W-1:0] endCore = stCore[PIPE_STAGES];
    wire op_t endOp = stOp[PIPE_STAGES];
    // Gain correction is done once at the end rather than in every stage
    wire logic signed [GAIN_PROD_W-1:0] scaledX =
        $signed(stP0[PIPE_STAGES]) * $signed({1'b0, GAIN_INV});
    wire logic signed [GAIN_PROD_W-1:0] scaledY =
        $signed(stP1[PIPE_STAGES]) * $signed({1'b0, GAIN_INV});
    // Gain fraction and guard bits dropped together
    wire word_t cordX = scaledX[GUARD_W+DWORD_W-1 -: WORD_W];
    wire word_t cordY = scaledY[GUARD_W+DWORD_W-1 -: WORD_W];

    // Slot wheel: one slot per core, round robin
    assign next_slotCore = (slotCore == CORE_W'(SLOT_PERIOD - 1)) ?
        '0 : slotCore + CORE_W'(1);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            slotCore <= '0;
            cmdRefused <= 1'b0;
        end else begin
            slotCore <= next_slotCore;
            cmdRefused <= refuse;
        end
    end

    log_exp_unit u_log_exp (
        .toInteger(cmdOp == OP_EXP),
        .value(cmdA),
        .result(logExpOut)
    );

    always_comb begin
        issueP0 = '0;
        issueP1 = '0;
        issueP2 = '0;
        case (cmdOp)
            OP_MUL: begin
                issueP0 = DWORD_W'(cmdA);
                issueP2 = cmdB;
            end
            OP_INT_DIV: begin
                issueP0 = DWORD_W'(cmdB);
                issueP1 = {extWord, cmdA};
            end
            OP_FRAC_DIV: begin
                issueP0 = DWORD_W'(cmdB);
                issueP1 = {cmdA, extWord};
            end
            OP_SQRT: begin
                issueP1 = {cmdB, cmdA};
            end
            OP_ROTATE: begin
                // Fold angles in the back half plane by a half turn
                issueP0 = flipRot ? -xWide : xWide;
                issueP1 = flipRot ? -yWide : yWide;
                issueP2 = flipRot ? cmdB + HALF_TURN : cmdB;
            end
            OP_VECTOR: begin
                issueP0 = flipVec ? -xWide : xWide;
                issueP1 = flipVec ? -yWide : yWide;
                issueP2 = flipVec ? HALF_TURN : '0;
            end
            OP_LOG, OP_EXP: begin
                issueP2 = logExpOut;
            end
            default: begin
                issueP2 = '0;
            end
        endcase
    end

    assign stValid[0] = issue;
    assign stCore[0] = cmdCore;
    assign stOp[0] = cmdOp;
    assign stP0[0] = issueP0;
    assign stP1[0] = issueP1;
    assign stP2[0] = issueP2;

    generate
        for (genvar k = 0; k < PIPE_STAGES; k++) begin : g_stage
            cordic_stage #(
                .IDX(k)
            ) u_stage (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .inValid(stValid[k]),
                .inCore(stCore[k]),
                .inOp(stOp[k]),
                .inP0(stP0[k]),
                .inP1(stP1[k]),
                .inP2(stP2[k]),
                .outValid(stValid[k+1]),
                .outCore(stCore[k+1]),
                .outOp(stOp[k+1]),
                .outP0(stP0[k+1]),
                .outP1(stP1[k+1]),
                .outP2(stP2[k+1])
            );
        end
    endgenerate

    always_comb begin
        finX = stP2[PIPE_STAGES];
        finY = '0;
        case (endOp)
            OP_MUL: begin
                finX = stP1[PIPE_STAGES][WORD_W-1:0];
                finY = stP1[PIPE_STAGES][DWORD_W-1:WORD_W];
            end
            OP_INT_DIV, OP_FRAC_DIV: begin
                finY = stP1[PIPE_STAGES][WORD_W-1:0];
            end
            OP_ROTATE: begin
                finX = cordX;
                finY = cordY;
            end
            OP_VECTOR: begin
                finX = cordX;
                finY = stP2[PIPE_STAGES];
            end
            default: begin
                finY = '0;
            end
        endcase
    end

    // Extension word is held per core and spent by that core's next accepted op
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int c = 0; c < CORE_COUNT; c++) begin
                extendWord[c] <= '0;
            end
        end else if (isExtend) begin
            extendWord[cmdCore] <= cmdA;
        end else if (issue) begin
            extendWord[cmdCore] <= '0;
        end
    end

    // Per-core result words, a new result simply replaces the old
    always_ff @(posedge clk_sys) begin
        if (endValid) begin
            resultX[endCore] <= finX;
            resultY[endCore] <= finY;
        end
    end

    // Fresh flags: arrival wins over a read in the same cycle
    generate
        for (genvar c = 0; c < CORE_COUNT; c++) begin : g_fresh
            wire logic arrive = endValid && (endCore == CORE_W'(c));
            wire logic takeX = readX && (cmdCore == CORE_W'(c));
            wire logic takeY = readY && (cmdCore == CORE_W'(c));
            assign next_freshX[c] = arrive || (freshX[c] && !takeX);
            assign next_freshY[c] = arrive || (freshY[c] && !takeY);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            freshX <= '0;
            freshY <= '0;
            resultLost <= 1'b0;
        end else begin
            freshX <= next_freshX;
            freshY <= next_freshY;
            resultLost <= endValid && (freshX[endCore] || freshY[endCore]);
        end
    end

    // Reads return one word per command
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdDataValid <= 1'b0;
            rdFresh <= 1'b0;
            rdData <= '0;
        end else begin
            rdDataValid <= readX || readY;
            rdFresh <= readY ? freshY[cmdCore] : freshX[cmdCore];
            rdData <= readY ? resultY[cmdCore] : resultX[cmdCore];
        end
    end
endmodule // cordic_solver

//--- bench/cordic_chk.sv
// Port assertions for the shared solver
`timescale 1ns/1ps
module cordic_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [cordic_pkg::CORE_W-1:0] cmdCore,
    input wire cordic_pkg::op_t cmdOp,
    input wire logic [cordic_pkg::CORE_W-1:0] slotCore,
    input wire logic cmdRefused,
    input wire logic rdDataValid,
    input wire logic resultLost
);
    import cordic_pkg::*;
    logic [55:0] accHist;
    wire solverOp = cmdValid && cmdOp <= OP_EXP;
    wire reading = cmdValid && (cmdOp == OP_READ_X || cmdOp == OP_READ_Y);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Accepted ops in flight, so a lost result can be tied to its issue
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accHist <= '0;
        end else begin
            accHist <= {accHist[54:0], solverOp && cmdCore == slotCore};
        end
    end
    // Skips the first cycles after release, where the slot may hold at 0
    a_slot_step: assert property ($past(rst_n) && $past(rst_n, 2) |->
        slotCore == 3'($past(slotCore) + 3'h1)) else $error("slot counter did not step");
    a_slot_wrap: assert property (slotCore == 3'h7 |=> slotCore == 3'h0)
        else $error("slot counter did not wrap");
    a_slot_reset: assert property (!$past(rst_n) |-> slotCore == 3'h0 && !cmdRefused
        && !rdDataValid && !resultLost) else $error("outputs not clear after reset");
    a_refuse_match: assert property ($past(rst_n) |->
        cmdRefused == $past(solverOp && cmdCore != slotCore)) else $error("refusal wrong");
    a_read_answer: assert property ($past(rst_n) |-> rdDataValid == $past(reading))
        else $error("read answer missing or spurious");
    a_extend_free: assert property (cmdValid && cmdOp >= OP_EXTEND |=> !cmdRefused)
        else $error("extension or read refused");
    a_refused_nodata: assert property (cmdRefused |-> !rdDataValid)
        else $error("refused op produced data");
    a_lost_latency: assert property (resultLost |-> accHist[54] || accHist[55])
        else $error("lost result without op in flight");
endmodule // cordic_chk

bind cordic_solver cordic_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdCore(cmdCore), .cmdOp(cmdOp), .slotCore(slotCore), .cmdRefused(cmdRefused),
    .rdDataValid(rdDataValid), .resultLost(resultLost));

//--- bench/core_model.sv
// Processor core model issuing solver commands in hub slots
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    input wire logic [cordic_pkg::CORE_W-1:0] slotCore,
    input wire logic rdDataValid,
    input wire logic rdFresh,
    input wire logic [cordic_pkg::WORD_W-1:0] rdData,
    output logic cmdValid,
    output logic [cordic_pkg::CORE_W-1:0] cmdCore,
    output cordic_pkg::op_t cmdOp,
    output logic [cordic_pkg::WORD_W-1:0] cmdA,
    output logic [cordic_pkg::WORD_W-1:0] cmdB
);
    import cordic_pkg::*;
    initial begin
        cmdValid = 1'b0;
        cmdCore = 3'h0;
        cmdOp = OP_MUL;
        cmdA = 32'h0;
        cmdB = 32'h0;
    end
    // Released operands flip so stale values never pass as valid
    task automatic idle();
        cmdValid <= 1'b0;
        cmdA <= ~cmdA;
        cmdB <= ~cmdB;
    endtask
    task automatic issue(input logic [2:0] core, input op_t op, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] ext, input bit useExt, input bit wrong);
        logic [2:0] lead;
        lead = (useExt || wrong) ? 3'h2 : 3'h1;
        do @(negedge clk_sys); while (slotCore !== 3'(core - lead));
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCore <= core;
        if (useExt) begin
            cmdOp <= OP_EXTEND;
            cmdA <= ext;
            @(posedge clk_sys);
        end
        cmdOp <= op;
        cmdA <= a;
        cmdB <= b;
        @(posedge clk_sys);
        idle();
    endtask
    task automatic readWord(input logic [2:0] core, input bit isY, input int gap,
        output logic [31:0] data, output logic fresh, output logic valid);
        repeat (gap + 1) @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCore <= core;
        cmdOp <= isY ? OP_READ_Y : OP_READ_X;
        @(posedge clk_sys);
        idle();
        @(negedge clk_sys);
        data = rdData;
        fresh = rdFresh;
        valid = rdDataValid;
    endtask
endmodule // core_model

//--- bench/tb_top.sv
// Self-checking bench for the shared solver
`timescale 1ns/1ps
module tb_top;
    import cordic_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic cmdValid;
    logic [CORE_W-1:0] cmdCore;
    op_t cmdOp;
    logic [WORD_W-1:0] cmdA;
    logic [WORD_W-1:0] cmdB;
    logic [CORE_W-1:0] slotCore;
    logic cmdRefused;
    logic rdDataValid;
    logic rdFresh;
    logic [WORD_W-1:0] rdData;
    logic resultLost;
    int failures = 0;
    int checksDone = 0;
    int cycles = 0;
    int lostCount = 0;
    cordic_solver u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdCore(cmdCore), .cmdOp(cmdOp), .cmdA(cmdA), .cmdB(cmdB), .slotCore(slotCore),
        .cmdRefused(cmdRefused), .rdDataValid(rdDataValid), .rdFresh(rdFresh),
        .rdData(rdData), .resultLost(resultLost));
    core_model u_core (.clk_sys(clk_sys), .slotCore(slotCore), .rdDataValid(rdDataValid),
        .rdFresh(rdFresh), .rdData(rdData), .cmdValid(cmdValid), .cmdCore(cmdCore),
        .cmdOp(cmdOp), .cmdA(cmdA), .cmdB(cmdB));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Whole run needs about 800 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (resultLost === 1'b1) lostCount++;
        if (cycles == 4000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Tolerance covers the few-LSB error of the rotation results
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp,
        input int tol);
        int d;
        d = $signed(seen - exp);
        if (d < 0) d = -d;
        checksDone++;
        if (seen !== exp && (d > tol || ^seen === 1'bx)) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic t_ops();
        op_t ops[9] = '{OP_MUL, OP_INT_DIV, OP_FRAC_DIV, OP_SQRT, OP_LOG, OP_EXP, OP_ROTATE,
            OP_ROTATE, OP_VECTOR};
        logic [31:0] av[9] = '{32'hFFFFFFFF, 32'h7, 32'h1, 32'h0, 32'h12345, 32'h811A2800,
            32'h0, 32'hF4240, 32'h2DC6C0};
        logic [31:0] bv[9] = '{32'hFFFFFFFF, 32'h100, 32'h3, 32'h9, 32'h0, 32'h0,
            32'h40000000, 32'h40000000, 32'h3D0900};
        logic [31:0] ev[9] = '{32'h0, 32'h5, 32'h2, 32'h0, 32'h0, 32'h0, 32'h1E8480, 32'h0, 32'h0};
        logic [31:0] xv[9] = '{32'h1, 32'h5000000, 32'h55555556, 32'h30000, 32'h811A2800,
            32'h12345, 32'hFFE17B80, 32'h0, 32'h4C4B40};
        logic [31:0] yv[9] = '{32'hFFFFFFFE, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
            32'hF4240, 32'h0};
        int tl[9] = '{0, 0, 0, 1, 0, 0, 16, 16, 16};
        logic [2:0] core;
        logic [31:0] x;
        logic f;
        logic v;
        yv[8] = 32'(longint'($atan2(4.0, 3.0) / TWO_PI * TURN_SCALE));
        for (int i = 0; i < 9; i++) begin
            // Row 7 reuses core 6 so a stale extension word would show
            core = (i == 7) ? 3'h6 : 3'(i);
            u_core.issue(core, ops[i], av[i], bv[i], ev[i], ev[i] != 0, 1'b0);
            repeat (53) @(posedge clk_sys);
            u_core.readWord(core, 1'b0, 0, x, f, v);
            check("result x", x, xv[i], tl[i]);
            check("x valid fresh", 32'({v, f}), 32'h3, 0);
            u_core.readWord(core, 1'b1, 0, x, f, v);
            check("result y", x, yv[i], tl[i]);
        end
        $display("test ops done");
    endtask
    task automatic t_refuse();
        logic [31:0] x;
        logic f;
        logic v;
        u_core.issue(3'h4, OP_MUL, 32'h2, 32'h3, 32'h0, 1'b0, 1'b1);
        @(negedge clk_sys);
        check("refused", 32'(cmdRefused), 32'h1, 0);
        repeat (53) @(posedge clk_sys);
        u_core.readWord(3'h4, 1'b0, 0, x, f, v);
        check("refused x", 32'({x, f}), 32'h2345000, 0);
        $display("test refuse done");
    endtask
    task automatic t_stream();
        int lost0;
        logic [31:0] x;
        logic f;
        logic v;
        lost0 = lostCount;
        u_core.issue(3'h2, OP_MUL, 32'h3, 32'h5, 32'h0, 1'b0, 1'b0);
        u_core.issue(3'h5, OP_MUL, 32'h7, 32'h7, 32'h0, 1'b0, 1'b0);
        u_core.issue(3'h2, OP_MUL, 32'hB, 32'hD, 32'h0, 1'b0, 1'b0);
        repeat (45) @(posedge clk_sys);
        u_core.readWord(3'h2, 1'b0, 0, x, f, v);
        check("stream x1", x, 32'hF, 0);
        u_core.readWord(3'h2, 1'b1, 0, x, f, v);
        check("stream y1", x, 32'h0, 0);
        u_core.readWord(3'h5, 1'b0, 0, x, f, v);
        check("other core", x, 32'h31, 0);
        u_core.readWord(3'h2, 1'b0, 1, x, f, v);
        check("early read", 32'({x[7:0], f}), 32'h1E, 0);
        u_core.readWord(3'h2, 1'b0, 0, x, f, v);
        check("stream x2", 32'({x[7:0], f}), 32'h11F, 0);
        check("no loss", 32'(lostCount - lost0), 32'h0, 0);
        $display("test stream done");
    endtask
    task automatic t_overwrite();
        int lost0;
        logic [31:0] x;
        logic f;
        logic v;
        lost0 = lostCount;
        u_core.issue(3'h1, OP_MUL, 32'h2, 32'h3, 32'h0, 1'b0, 1'b0);
        u_core.issue(3'h1, OP_MUL, 32'h4, 32'h5, 32'h0, 1'b0, 1'b0);
        repeat (53) @(posedge clk_sys);
        u_core.readWord(3'h1, 1'b0, 0, x, f, v);
        check("overwritten x", 32'({x[7:0], f}), 32'h29, 0);
        check("loss count", 32'(lostCount - lost0), 32'h1, 0);
        $display("test overwrite done");
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_ops();
        t_refuse();
        t_stream();
        t_overwrite();
        test_done();
    end
endmodule // tb_top
